//--- rtl/lodt_consts.svh
// Offsets, field positions, reset values and widths for the lane output delay tap registers
`ifndef LODT_CONSTS_SVH
`define LODT_CONSTS_SVH

`define LODT_LANE2_IDX 6'h0D
`define LODT_LANE3_IDX 6'h0E
`define LODT_COARSE_IDX 6'h20
`define LODT_ADDR_W 8
`define LODT_LANES 2
`define LODT_DLY_W 9
`define LODT_DLY_MSB 8
`define LODT_CTRL_LSB 13
`define LODT_CTRL_MSB 15
`define LODT_CRSE_BIT 13
`define LODT_DEC_BIT 14
`define LODT_INC_BIT 15
`define LODT_DLY_RESET 9'h000
`define LODT_COARSE_RESET 9'h000
`define LODT_FAB_LSB 18
`define LODT_FAB_MSB 35

`endif

//--- rtl/lodt_pkg.sv
// Types shared by the lane output delay tap register bank
package lodt_pkg;

  typedef struct packed {
    logic coarse_select;
    logic step_down;
    logic step_up;
  } lodt_ctrl_t;

  typedef enum logic [1:0] {
    LODT_OP_LOAD,
    LODT_OP_STEP,
    LODT_OP_COARSE
  } lodt_op_t;

  typedef struct packed {
    logic [8:0] lane3_delay_value;
    logic [8:0] lane2_delay_value;
  } lodt_fabric_count_t;

endpackage : lodt_pkg

//--- rtl/lodt_regs.sv
// APB register bank for the lane 2 and lane 3 output delay tap settings
//
// Overview of operation
// - Lane 3 read returns applied tap setting
// - Lane 2 read returns applied tap setting
// - Patterns 000/011/100/111 load written value
// - Pattern 001 adds one tap, wraps
// - Pattern 010 subtracts one tap, wraps
// - Pattern 101 adds coarse step modulo 512
// - Pattern 110 subtracts coarse step modulo 512
// - Control bits 13..15, write-only, reset zero
// - Lane 2 register at index 0x0d
// - Lane 3 at index 0x0e, resets zero
// - Lane 3 value equals fabric count out
// - Lane 3 load equals fabric slice load
// - Lane 2 load equals fabric slice load
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "lodt_consts.svh"

module lodt_regs (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`LODT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`LODT_LANES-1:0] fabric_load,
  input wire logic [`LODT_FAB_MSB:`LODT_FAB_LSB] fabric_delay_count_in,
  output logic [`LODT_FAB_MSB:`LODT_FAB_LSB] fabric_delay_count_out
);

  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [8:0] coarse_step_reg;
  logic [8:0] delay_reg [`LODT_LANES];
  logic [8:0] delay_next [`LODT_LANES];
  logic [`LODT_LANES-1:0] fab_load_s1_reg;
  logic [`LODT_LANES-1:0] fab_load_s2_reg;
  logic [17:0] fab_in_s1_reg;
  logic [17:0] fab_in_s2_reg;
  lodt_pkg::lodt_fabric_count_t fab_out_reg;

  // Address decode on word index; byte address is four times the index
  wire logic [5:0] word_idx = paddr[7:2];
  wire logic sel_lane2 = (word_idx == `LODT_LANE2_IDX);
  wire logic sel_lane3 = (word_idx == `LODT_LANE3_IDX);
  wire logic sel_coarse = (word_idx == `LODT_COARSE_IDX);
  wire logic addr_hit = sel_lane2 | sel_lane3 | sel_coarse;
  wire logic access = psel & penable;
  wire logic commit = access & pready_reg;
  wire logic wr_commit = commit & pwrite & ~pslverr_reg;
  // Only the two low byte lanes carry defined bits
  wire logic wr_lo = pstrb[0];
  wire logic wr_hi = pstrb[1];
  wire logic [`LODT_LANES-1:0] lane_wr = {wr_commit & sel_lane3, wr_commit & sel_lane2};

  lodt_pkg::lodt_ctrl_t wr_ctrl;
  // The word holds increment at the top and coarse at the bottom, the reverse of the struct order
  assign wr_ctrl = {pwdata[`LODT_CRSE_BIT], pwdata[`LODT_DEC_BIT], pwdata[`LODT_INC_BIT]};

  lodt_pkg::lodt_op_t wr_op;
  assign wr_op = (wr_ctrl.step_up ^ wr_ctrl.step_down) ?
                 (wr_ctrl.coarse_select ? lodt_pkg::LODT_OP_COARSE : lodt_pkg::LODT_OP_STEP) :
                 lodt_pkg::LODT_OP_LOAD;

  wire logic [8:0] step_amount = (wr_op == lodt_pkg::LODT_OP_COARSE) ? coarse_step_reg : 9'h001;
  wire logic step_is_up = wr_ctrl.step_up;

  // The control bits live in byte lane 1, so a step needs that lane; the value byte alone
  // cannot form a full 9-bit load, so a load needs both lanes
  wire logic step_ok = wr_hi & (wr_op != lodt_pkg::LODT_OP_LOAD);
  wire logic load_ok = wr_lo & wr_hi & (wr_op == lodt_pkg::LODT_OP_LOAD);

  genvar g;
  generate
    for (g = 0; g < `LODT_LANES; g++) begin : g_lane
      wire logic [8:0] fab_slice = fab_in_s2_reg[g*9 +: 9];
      wire logic [8:0] up_val = delay_reg[g] + step_amount;
      wire logic [8:0] down_val = delay_reg[g] - step_amount;
      wire logic [8:0] step_val = step_is_up ? up_val : down_val;
      assign delay_next[g] = (lane_wr[g] & step_ok) ? step_val :
                             (lane_wr[g] & load_ok) ? pwdata[`LODT_DLY_MSB:0] :
                             fab_load_s2_reg[g] ? fab_slice :
                             delay_reg[g];

      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          delay_reg[g] <= `LODT_DLY_RESET;
        end else begin
          delay_reg[g] <= delay_next[g];
        end
      end
    end
  endgenerate

  // Fabric inputs come from another clock region; two stages before use
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fab_load_s1_reg <= '0;
      fab_load_s2_reg <= '0;
      fab_in_s1_reg <= '0;
      fab_in_s2_reg <= '0;
    end else begin
      fab_load_s1_reg <= fabric_load;
      fab_load_s2_reg <= fab_load_s1_reg;
      fab_in_s1_reg <= fabric_delay_count_in;
      fab_in_s2_reg <= fab_in_s1_reg;
    end
  end

  // Count output mirrors the applied settings
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fab_out_reg <= '0;
    end else begin
      fab_out_reg.lane2_delay_value <= delay_next[0];
      fab_out_reg.lane3_delay_value <= delay_next[1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      coarse_step_reg <= `LODT_COARSE_RESET;
    end else if (wr_commit & sel_coarse & wr_lo & wr_hi) begin
      coarse_step_reg <= pwdata[`LODT_DLY_MSB:0];
    end
  end

  // Read data: control bits are write-only and reserved bits read zero
  wire logic [31:0] rd_mux = sel_lane2 ? {23'h000000, delay_reg[0]} :
                             sel_lane3 ? {23'h000000, delay_reg[1]} :
                             sel_coarse ? {23'h000000, coarse_step_reg} :
                             32'h00000000;

  // One wait state: pready rises in the second access cycle, giving time to latch read data
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~addr_hit;
      if (access & ~pready_reg & ~pwrite) begin
        prdata_reg <= rd_mux;
      end else if (commit) begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  assign fabric_delay_count_out = fab_out_reg;

endmodule : lodt_regs

`default_nettype wire

//--- verif/lodt_regs_sva.sv
// Assertion checker for the lane output delay tap registers
`timescale 1ns/100ps
`default_nettype none
module lodt_regs_sva (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [35:18] fabric_delay_count_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire rd_end = pready && !pwrite;
  wire wr3 = pready && pwrite && paddr[7:2] == 6'h0E && pstrb[1:0] == 2'h3;
  wire [8:0] l3 = fabric_delay_count_out[35:27];
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stale read data");
  property p_err; pslverr |-> pready && paddr[7:2] != 6'h0D && paddr[7:2] != 6'h0E && paddr[7:2] != 6'h20; endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_rsv; rd_end |-> prdata[31:9] == 23'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("upper bits not zero");
  property p_rd3; rd_end && paddr[7:2] == 6'h0E |-> prdata[8:0] == l3; endproperty
  a_rd3: assert property (p_rd3) else $error("lane3 read mismatch");
  property p_rd2; rd_end && paddr[7:2] == 6'h0D |-> prdata[8:0] == fabric_delay_count_out[26:18]; endproperty
  a_rd2: assert property (p_rd2) else $error("lane2 read mismatch");
  property p_inc; wr3 && pwdata[15:13] == 3'b100 |=> l3 == $past(l3) + 9'h1; endproperty
  a_inc: assert property (p_inc) else $error("step up wrong");
  property p_dec; wr3 && pwdata[15:13] == 3'b010 |=> l3 == $past(l3) - 9'h1; endproperty
  a_dec: assert property (p_dec) else $error("step down wrong");
  property p_ld; wr3 && pwdata[15:13] == 3'b000 |=> l3 == $past(pwdata[8:0]); endproperty
  a_ld: assert property (p_ld) else $error("load wrong");
  c_wr: cover property (wr3);
  c_err: cover property (pslverr);
  c_rd: cover property (rd_end);
  c_step: cover property (wr3 && (pwdata[15] ^ pwdata[14]));
endmodule : lodt_regs_sva
bind lodt_regs lodt_regs_sva u_sva (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .fabric_delay_count_out(fabric_delay_count_out)
);
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the lane output delay tap registers
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] fabric_load;
  logic [35:18] fabric_delay_count_in, fabric_delay_count_out;
  int num_errors, samples_checked;
  // Top three bits are word bits 15..13: increment, decrement, coarse select
  logic [11:0] op [8] = '{12'h1FF, 12'h8AA, 12'h4AB, 12'hA33, 12'h600, 12'hC12, 12'h234, 12'hE56};
  logic [8:0] ex [8] = '{9'h1FF, 9'h000, 9'h1FF, 9'h004, 9'h1FF, 9'h012, 9'h034, 9'h056};
  lodt_regs u_dut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .fabric_load(fabric_load),
    .fabric_delay_count_in(fabric_delay_count_in),
    .fabric_delay_count_out(fabric_delay_count_out)
  );
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // Look at pready mid-cycle where it has settled; the next rising edge completes the transfer
    do begin
      @(negedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      summarize();
    end else begin
      rd = prdata;
      err = pslverr;
      @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fabric_load, fabric_delay_count_in} = '0;
    pstrb = 4'hF;
    rst_b = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h34, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    chk(rd, 32'h0);
    $display("test reset values done");
    // Coarse step of 5 makes both coarse ops wrap from the ends of the range
    apb(1'b1, 8'h80, 32'h5);
    for (int l = 0; l < 2; l++) begin
      for (int i = 0; i < 8; i++) begin
        apb(1'b1, 8'h34 + 8'(4 * l), {16'h0, op[i][11:9], 4'hF, op[i][8:0]});
        apb(1'b0, 8'h34 + 8'(4 * l), 32'h0);
        chk(rd, {23'h0, ex[i]});
        chk({23'h0, fabric_delay_count_out[26 + 9 * l -: 9]}, {23'h0, ex[i]});
      end
    end
    $display("test lane ops done");
    fabric_delay_count_in <= {9'h0C3, 9'h15A};
    fabric_load <= 2'b11;
    repeat (5) @(posedge core_clk);
    fabric_load <= 2'b00;
    apb(1'b0, 8'h34, 32'h0);
    chk(rd, 32'h15A);
    apb(1'b0, 8'h38, 32'h0);
    chk(rd, 32'h0C3);
    apb(1'b0, 8'h3C, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test fabric and unmapped done");
    // A load with only the value byte enabled cannot form a 9-bit value and is dropped
    pstrb <= 4'h1;
    apb(1'b1, 8'h34, 32'h000000AA);
    pstrb <= 4'hF;
    apb(1'b0, 8'h34, 32'h0);
    chk(rd, 32'h15A);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h38, 32'h0);
    chk(rd, 32'h0);
    chk({23'h0, fabric_delay_count_out[35:27]}, 32'h0);
    $display("test refusal and mid-run reset done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
